// file: hw/adsi_pkg.sv
// Constants and types for the converter serial interface
package adsi_pkg;

  localparam int unsigned FRAME_BITS       = 19;
  localparam int unsigned DATA_BITS        = 16;
  localparam int unsigned SDI_BITS         = 8;
  localparam int unsigned CLK_PERIOD_NS    = 20;
  localparam int unsigned CONVERT_TIME_MS  = 147;
  localparam int unsigned CONVERT_CYCLES   =
    (CONVERT_TIME_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned EXT_CONV_PERIODS = 20510;
  localparam int unsigned INT_OSC_NS       = 7171;
  localparam int unsigned INT_OSC_CYCLES   = INT_OSC_NS / CLK_PERIOD_NS;
  localparam int unsigned SCK_DIV          = 8;
  localparam int unsigned EXT_OSC_MIN_HZ   = 2560;
  localparam int unsigned EXT_OSC_TIMEOUT  =
    1000000000 / (EXT_OSC_MIN_HZ * CLK_PERIOD_NS);
  localparam logic [4:0]  LAST_FALL_IDX    = 5'h12;
  localparam logic [3:0]  LAST_SDI_IDX     = 4'h7;
  localparam logic [2:0]  PREFIX_LOAD      = 3'h5;
  localparam logic [4:0]  CHAN_RESET       = 5'h00;

  typedef enum logic [1:0] {
    ST_CONVERT,
    ST_SLEEP,
    ST_OUTPUT
  } adsi_state_e;

  typedef struct packed {
    logic       single_ended_select;
    logic [3:0] chan;
  } adsi_chan_s;

  typedef struct packed {
    logic        eoc_n;
    logic        filler_bit;
    logic        sign_bit;
    logic [15:0] data;
  } adsi_frame_s;

endpackage

// file: hw/adsi_core.sv
// Serial interface and conversion sequencing of the converter
`timescale 1ns/1ps
`default_nettype none
module adsi_core
  import adsi_pkg::*;
#(
  parameter int unsigned CONV_CYCLES  = CONVERT_CYCLES,
  parameter int unsigned EXT_PERIODS  = EXT_CONV_PERIODS,
  parameter int unsigned OSC_TIMEOUT  = EXT_OSC_TIMEOUT,
  parameter int unsigned OSC_DIV      = INT_OSC_CYCLES
) (
  input  wire logic        clk_i,              // System clock
  input  wire logic        srst_i,             // Sync reset
  input  wire logic        cs_n_i,             // Chip select
  input  wire logic        sck_i,              // SCK pin level
  output logic             sck_o,              // SCK drive value
  output logic             sck_oe_o,           // SCK drive enable
  input  wire logic        sdi_i,              // Serial data in
  output logic             sdo_o,              // Serial data out
  output logic             sdo_oe_o,           // SDO drive enable
  input  wire logic        rejection_clock_i,  // Rejection clock pin
  input  wire logic        conv_sign_i,        // Result sign
  input  wire logic [15:0] conv_data_i,        // Result code
  input  wire logic        conv_over_i,        // Above full scale
  input  wire logic        conv_under_i,       // Below full scale
  output logic             conv_start_o,       // Conversion start
  output adsi_chan_s       conv_chan_o,        // Active channel
  output logic             ext_osc_o,          // External osc used
  output logic             ext_sck_o           // External SCK mode
);

  adsi_state_e state_reg;
  adsi_frame_s shift_reg;
  adsi_chan_s  next_chan_reg;
  adsi_chan_s  conv_chan_reg;
  logic [31:0] conv_cnt_reg;
  logic [31:0] osc_idle_reg;
  logic [31:0] osc_div_reg;
  logic [4:0]  bit_cnt_reg;
  logic [3:0]  sdi_cnt_reg;
  logic [6:0]  sdi_sr_reg;
  logic [1:0]  sck_div_reg;
  logic        sck_int_reg;
  logic        sck_prev_reg;
  logic        cs_prev_reg;
  logic        rcp_prev_reg;
  logic        ext_osc_reg;
  logic        ext_sck_reg;
  logic        por_pend_reg;
  logic        start_pend_reg;
  logic        conv_start_reg;

  logic        cs_fall;
  logic        cs_rise;
  logic        rcp_rise;
  logic        conv_tick;
  logic        sck_val;
  logic        sck_rise;
  logic        sck_fall;
  logic        sck_run;
  logic        conv_done;
  logic        start_conv;
  logic        capture_en;
  logic        last_fall;
  logic [7:0]  sdi_full;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (srst_i);

  assign cs_fall  = cs_prev_reg & ~cs_n_i;
  assign cs_rise  = ~cs_prev_reg & cs_n_i;
  assign rcp_rise = rejection_clock_i & ~rcp_prev_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      cs_prev_reg  <= 1'b1;
      rcp_prev_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
    end else begin
      cs_prev_reg  <= cs_n_i;
      rcp_prev_reg <= rejection_clock_i;
      sck_prev_reg <= sck_val;
    end
  end

  // Edges on the pin mean an external oscillator; silence falls back
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      ext_osc_reg  <= 1'b0;
      osc_idle_reg <= '0;
    end else if (rcp_rise) begin
      ext_osc_reg  <= 1'b1;
      osc_idle_reg <= '0;
    end else if (osc_idle_reg >= OSC_TIMEOUT - 1) begin
      ext_osc_reg  <= 1'b0;
    end else begin
      osc_idle_reg <= osc_idle_reg + 32'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i || osc_div_reg >= OSC_DIV - 1) begin
      osc_div_reg <= '0;
    end else begin
      osc_div_reg <= osc_div_reg + 32'h1;
    end
  end

  assign conv_tick = ext_osc_reg ? rcp_rise : (osc_div_reg == OSC_DIV - 1);

  // Mode strap caught just after reset and on every select fall
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      por_pend_reg <= 1'b1;
      ext_sck_reg  <= 1'b0;
    end else if (por_pend_reg || cs_fall) begin
      por_pend_reg <= 1'b0;
      ext_sck_reg  <= ~sck_i;
    end
  end

  assign sck_run = ~ext_sck_reg & ~cs_n_i &
                   (state_reg == ST_SLEEP || state_reg == ST_OUTPUT);

  // Internal SCK toggles every fourth conversion clock tick
  always_ff @(posedge clk_i) begin
    if (srst_i || !sck_run) begin
      sck_div_reg <= '0;
      sck_int_reg <= 1'b0;
    end else if (conv_tick) begin
      if (sck_div_reg == 2'(SCK_DIV / 2 - 1)) begin
        sck_div_reg <= '0;
        sck_int_reg <= ~sck_int_reg;
      end else begin
        sck_div_reg <= sck_div_reg + 2'h1;
      end
    end
  end

  // No drive while the mode strap is read, or SCK would strap itself low
  assign sck_o    = sck_int_reg;
  assign sck_oe_o = ~ext_sck_reg & ~cs_n_i & ~cs_prev_reg & ~por_pend_reg;
  assign sck_val  = ext_sck_reg ? sck_i : sck_int_reg;
  assign sck_rise = sck_val & ~sck_prev_reg;
  assign sck_fall = ~sck_val & sck_prev_reg;

  assign conv_done = (state_reg == ST_CONVERT) && !start_pend_reg &&
    (ext_osc_reg ? (conv_cnt_reg >= EXT_PERIODS - 1 && conv_tick)
                 : (conv_cnt_reg >= CONV_CYCLES - 1));

  assign last_fall  = sck_fall && (bit_cnt_reg == LAST_FALL_IDX);
  assign start_conv = start_pend_reg ||
    ((state_reg == ST_OUTPUT) && (last_fall || cs_rise));

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      start_pend_reg <= 1'b1;
      conv_start_reg <= 1'b0;
    end else begin
      start_pend_reg <= 1'b0;
      conv_start_reg <= start_conv;
    end
  end

  assign conv_start_o = conv_start_reg;

  always_ff @(posedge clk_i) begin
    if (srst_i || start_conv) begin
      conv_cnt_reg <= '0;
    end else if (state_reg == ST_CONVERT && (conv_tick || !ext_osc_reg)) begin
      conv_cnt_reg <= conv_cnt_reg + 32'h1;
    end
  end

  // Conversion state sequencing
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      state_reg   <= ST_CONVERT;
      bit_cnt_reg <= '0;
    end else if (start_conv) begin
      state_reg   <= ST_CONVERT;
      bit_cnt_reg <= '0;
    end else begin
      case (state_reg)
        ST_CONVERT: begin
          if (conv_done) begin
            state_reg <= ST_SLEEP;
          end
        end
        ST_SLEEP: begin
          if (!cs_n_i && sck_rise) begin
            state_reg   <= ST_OUTPUT;
            bit_cnt_reg <= '0;
          end
        end
        ST_OUTPUT: begin
          if (sck_fall) begin
            bit_cnt_reg <= bit_cnt_reg + 5'h1;
          end
        end
        default: state_reg <= ST_CONVERT;
      endcase
    end
  end

  // Result frame load and shift
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      shift_reg <= '0;
    end else if (conv_done) begin
      shift_reg.eoc_n      <= 1'b0;
      shift_reg.filler_bit <= 1'b0;
      if (conv_over_i) begin
        shift_reg.sign_bit <= 1'b1;
        shift_reg.data     <= 16'h8000;
      end else if (conv_under_i) begin
        shift_reg.sign_bit <= 1'b0;
        shift_reg.data     <= 16'h7FFF;
      end else begin
        shift_reg.sign_bit <= conv_sign_i;
        shift_reg.data     <= conv_data_i;
      end
    end else if (state_reg == ST_OUTPUT && sck_fall) begin
      shift_reg <= {shift_reg[FRAME_BITS-2:0], 1'b0};
    end
  end

  // Channel bits shift in on rising SCK only once selected and done
  assign capture_en = sck_rise && !cs_n_i && sdi_cnt_reg <= LAST_SDI_IDX &&
    (state_reg == ST_SLEEP || state_reg == ST_OUTPUT);
  assign sdi_full = {sdi_sr_reg, sdi_i};

  always_ff @(posedge clk_i) begin
    if (srst_i || start_conv) begin
      sdi_cnt_reg <= '0;
      sdi_sr_reg  <= '0;
    end else if (capture_en) begin
      sdi_cnt_reg <= sdi_cnt_reg + 4'h1;
      sdi_sr_reg  <= sdi_full[6:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      next_chan_reg <= CHAN_RESET;
    end else if (capture_en && sdi_cnt_reg == LAST_SDI_IDX &&
                 sdi_full[7:5] == PREFIX_LOAD) begin
      next_chan_reg <= sdi_full[4:0];
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      conv_chan_reg <= CHAN_RESET;
    end else if (start_conv) begin
      conv_chan_reg <= next_chan_reg;
    end
  end

  assign conv_chan_o = conv_chan_reg;
  assign ext_osc_o   = ext_osc_reg;
  assign ext_sck_o   = ext_sck_reg;

  // SDO source per state
  assign sdo_oe_o = ~cs_n_i;
  always_comb begin
    case (state_reg)
      ST_CONVERT: sdo_o = 1'b1;
      ST_SLEEP:   sdo_o = 1'b0;
      ST_OUTPUT:  sdo_o = shift_reg.eoc_n;
      default:    sdo_o = 1'b1;
    endcase
  end

  sequence seq_last_fall;
    state_reg == ST_OUTPUT && last_fall && !cs_rise;
  endsequence

  sequence seq_restart;
    state_reg == ST_CONVERT && conv_start_o ##1 sdo_o && !conv_start_o;
  endsequence

  chk_sdo_release: assert property (cs_n_i |-> !sdo_oe_o)
    else $error("SDO driven while deselected");

  chk_flag_convert: assert property (
    (state_reg == ST_CONVERT && !cs_n_i) |-> sdo_o)
    else $error("Pending flag low during conversion");

  chk_frame_end: assert property (seq_last_fall |=> seq_restart)
    else $error("No restart after nineteenth falling edge");

  chk_abort_restart: assert property (
    (state_reg == ST_OUTPUT && cs_rise) |=> state_reg == ST_CONVERT)
    else $error("Select rise did not abort output");

  chk_sleep_wake: assert property (
    (state_reg == ST_SLEEP && !cs_n_i && sck_rise) |=>
    state_reg == ST_OUTPUT && bit_cnt_reg == 5'h00)
    else $error("Sleep not left on rising SCK");

  chk_sleep_hold: assert property (
    (state_reg == ST_SLEEP && $past(state_reg) == ST_SLEEP) |->
    $stable(shift_reg))
    else $error("Result changed during sleep");

  chk_chan_next: assert property (
    !$stable(conv_chan_reg) |-> $past(start_conv))
    else $error("Channel changed outside conversion start");

  chk_filler_low: assert property (
    (state_reg == ST_OUTPUT && bit_cnt_reg == 5'h01) |->
    !sdo_o)
    else $error("Filler bit not low");

  chk_ignore_sdi: assert property (
    (state_reg == ST_CONVERT || cs_n_i) |=> $stable(next_chan_reg))
    else $error("SDI taken while ignored");

  chk_ext_sck_in: assert property (ext_sck_reg |-> !sck_oe_o)
    else $error("SCK driven in external mode");

  chk_strap_float: assert property ((cs_fall || por_pend_reg) |-> !sck_oe_o)
    else $error("SCK driven while mode strap sampled");

endmodule
`default_nettype wire

// file: verif/adsi_host.sv
// Host-side SPI master model for the converter link
`timescale 1ns/1ps
`default_nettype none
module adsi_host (
  input  wire logic clk_i,    // System clock
  input  wire logic sck_i,    // Resolved SCK pin
  input  wire logic sdo_i,    // Device data out
  output logic      cs_n_o,   // Chip select
  output logic      sck_o,    // Host SCK value
  output logic      sck_oe_o, // Host drives SCK
  output logic      sdi_o,    // Host data out
  output int        per_o     // Cycles between SCK rises
);
  int   gap;
  logic sck_q;
  initial begin
    cs_n_o = 1'b1;
    sck_o = 1'b0;
    sck_oe_o = 1'b0;
    sdi_o = 1'b0;
  end
  always @(posedge clk_i) begin
    sck_q <= sck_i;
    gap <= (sck_i && !sck_q) ? 1 : gap + 1;
    if (sck_i && !sck_q) per_o <= gap;
  end
  // Low SCK at select fall asks for external mode; released SCK floats high
  task automatic sel(input logic ext);
    if (cs_n_o) begin
      sck_oe_o <= ext;
      sck_o <= 1'b0;
      @(posedge clk_i);
      cs_n_o <= 1'b0;
    end
  endtask
  task automatic desel();
    cs_n_o <= 1'b1;
  endtask
  // Shift n bits; din goes out MSB first, later SDI bits toggle
  task automatic xfer(input logic ext, input int n, input logic [7:0] din, output logic [18:0] q);
    int   t;
    logic p;
    q = '0;
    for (t = 0; t < 2000 && sdo_i !== 1'b0; t++) @(posedge clk_i);
    sdi_o <= din[7];
    for (int i = 0; i < n; i++) begin
      if (ext) begin
        repeat (3) @(posedge clk_i);
        sck_o <= 1'b1;
      end else begin
        p = sck_i;
        @(negedge clk_i);
        for (t = 0; t < 64 && !(sck_i && !p); t++) begin
          p = sck_i;
          @(negedge clk_i);
        end
      end
      q = {q[17:0], sdo_i};
      if (ext) begin
        repeat (3) @(posedge clk_i);
        sck_o <= 1'b0;
      end else begin
        @(posedge clk_i);
      end
      sdi_o <= (i < 7) ? din[6-i] : ~sdi_o;
    end
  endtask
endmodule
`default_nettype wire

// file: verif/test_adsi_core.sv
// Self-checking bench for the converter serial interface
`timescale 1ns/1ps
`default_nettype none
module test_adsi_core;
  import adsi_pkg::*;
  localparam logic [23:0] PRE = 24'hA2CA25;
  logic        clk_i = 1'b0;
  logic        srst_i = 1'b1;
  logic        rclk = 1'b0;
  logic        rclk_en = 1'b0;
  logic [2:0]  rdiv = 3'h0;
  logic        conv_sign, conv_over, conv_under, got;
  logic [15:0] conv_data;
  logic        sck_o, sck_oe_o, sdo_o, sdo_oe_o, conv_start_o, ext_osc_o, ext_sck_o;
  logic        cs_n, h_sck, h_sck_oe, sdi, sdo_q;
  adsi_chan_s  conv_chan_o;
  wire logic   sck_pin;
  int          n_mismatch = 0;
  int          cmp_count = 0;
  int          cnt = 0;
  int          len = 0;
  int          per;
  logic [31:0] rs = 32'h00004FF3;

  assign sck_pin = sck_oe_o ? sck_o : (h_sck_oe ? h_sck : 1'b1);
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    rdiv <= rdiv + 3'h1;
    rclk <= rclk_en & rdiv[2];
    sdo_q <= sdo_o;
    cnt <= conv_start_o ? 0 : cnt + 1;
    if (conv_start_o) begin
      got <= 1'b0;
    end else if (!cs_n && sdo_q && !sdo_o && !got) begin
      len <= cnt;
      got <= 1'b1;
    end
  end

  adsi_core #(.CONV_CYCLES(200), .EXT_PERIODS(20), .OSC_TIMEOUT(50), .OSC_DIV(2)) dut_u (
    .clk_i(clk_i), .srst_i(srst_i), .cs_n_i(cs_n), .sck_i(sck_pin), .sck_o(sck_o),
    .sck_oe_o(sck_oe_o), .sdi_i(sdi), .sdo_o(sdo_o), .sdo_oe_o(sdo_oe_o),
    .rejection_clock_i(rclk), .conv_sign_i(conv_sign), .conv_data_i(conv_data),
    .conv_over_i(conv_over), .conv_under_i(conv_under), .conv_start_o(conv_start_o),
    .conv_chan_o(conv_chan_o), .ext_osc_o(ext_osc_o), .ext_sck_o(ext_sck_o));
  adsi_host host_u (.clk_i(clk_i), .sck_i(sck_pin), .sdo_i(sdo_o), .cs_n_o(cs_n),
    .sck_o(h_sck), .sck_oe_o(h_sck_oe), .sdi_o(sdi), .per_o(per));

  function automatic logic [31:0] rnd();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
    return rs;
  endfunction
  function automatic logic [18:0] exp_frame(input logic [31:0] r, input logic ov, input logic un);
    if (ov) return {3'h1, 16'h8000};
    if (un) return {3'h0, 16'h7FFF};
    return {2'h0, r[16:0]};
  endfunction
  task automatic chk(input logic [18:0] got_v, input logic [18:0] exp_v);
    cmp_count++;
    if (got_v !== exp_v) begin
      n_mismatch++;
      $display("[FAIL] %0t mismatch got %h expected %h", $time, got_v, exp_v);
    end
  endtask
  task automatic wait_hi(ref logic s, input int lim);
    for (int k = 0; k < lim && s !== 1'b1; k++) @(negedge clk_i);
  endtask
  task automatic results();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (60000) @(posedge clk_i);
    n_mismatch++;
    results();
  end

  initial begin
    logic [18:0] q;
    logic [7:0]  din;
    logic [4:0]  exp_chan;
    logic [31:0] r;
    logic        ext, ov, un;
    int          n, l;
    conv_sign = 1'b0;
    conv_data = 16'h0000;
    conv_over = 1'b0;
    conv_under = 1'b0;
    exp_chan = 5'h00;
    repeat (10) @(posedge clk_i);
    srst_i <= 1'b0;
    @(negedge clk_i);
    chk(sdo_oe_o, 1'b0);
    wait_hi(conv_start_o, 5);
    chk(conv_start_o, 1'b1);
    for (int it = 0; it < 8; it++) begin
      ext = (it < 6);
      n = (it == 5) ? 5 : 19;
      r = rnd();
      ov = (it == 1) || (it == 3);
      un = (it == 2) || (it == 3);
      din = {PRE[it*3 +: 3], r[20:16]};
      l = (it == 4) ? 160 : 200;
      @(posedge clk_i);
      rclk_en <= (it == 3) || (it == 4);
      conv_sign <= r[16];
      conv_data <= r[15:0];
      conv_over <= ov;
      conv_under <= un;
      if (it == 6) repeat (300) @(posedge clk_i);
      host_u.sel(ext);
      repeat (3) @(negedge clk_i);
      chk(ext_sck_o, ext);
      chk(sck_oe_o, !ext);
      chk(sdo_oe_o, 1'b1);
      chk(sdo_o, it != 6);
      @(posedge clk_i);
      host_u.xfer(ext, n, din, q);
      chk(conv_chan_o, exp_chan);
      if (it == 4) chk(ext_osc_o, 1'b1);
      if (it == 7) chk(ext_osc_o, 1'b0);
      if (it == 6) chk(per, 16);
      if (it != 3 && it != 5 && it != 6) chk(len > l - 10 && len < l + 10, 1'b1);
      if (n == 19) begin
        chk(q, exp_frame(r, ov, un));
        if (din[7:5] == PREFIX_LOAD) exp_chan = din[4:0];
      end else begin
        @(posedge clk_i);
        host_u.desel();
      end
      wait_hi(conv_start_o, 16);
      chk(conv_start_o, 1'b1);
      if (n == 19) chk(sdo_o, 1'b1);
      repeat (2) @(negedge clk_i);
      chk(conv_chan_o, exp_chan);
      @(posedge clk_i);
      if (it % 2 == 0) host_u.desel();
    end
    host_u.desel();
    repeat (2) @(negedge clk_i);
    chk(sdo_oe_o, 1'b0);
    results();
  end
endmodule
`default_nettype wire
